/* File: verilog/ext_bus_pkg.sv */
// ext_bus_pkg: constants and types shared by both ends of the external bus
// assumes: single 25 MHz clock, active-low asynchronous reset
package ext_bus_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int IO_W   = 8;
  localparam int PERIPH_N = 4;
  localparam int PERIPH_SEL_W = 2;
  // peripheral window in i/o space: base with low select bits
  localparam logic [IO_W-1:0]        PERIPH_BASE = 8'h10;
  localparam logic [IO_W-1:0]        PERIPH_MASK = 8'hfc;
  localparam logic [DATA_W-1:0]      DATA_RESET  = 8'h00;
  localparam logic [ADDR_W-1:0]      ADDR_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0]      VECTOR_DEFAULT = 8'hff;

  typedef enum logic [2:0] {
    CYC_FETCH   = 3'b000,
    CYC_MEM_RD  = 3'b001,
    CYC_MEM_WR  = 3'b010,
    CYC_IO_RD   = 3'b011,
    CYC_IO_WR   = 3'b100,
    CYC_INT_ACK = 3'b101,
    CYC_REFRESH = 3'b110
  } cyc_kind_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ADDR   = 2'b01,
    PH_STROBE = 2'b10,
    PH_END    = 2'b11
  } phase_t;
endpackage

/* File: verilog/ext_bus_if.sv */
// ext_bus_if: external bus wires between the processor end and the far end
// assumes: each end drives a pin only while its enable is high
`timescale 1ns/1ps
interface ext_bus_if;
  // processor end drive
  logic [15:0] dev_addr_o;
  logic        dev_addr_oe;
  logic [7:0]  dev_data_o;
  logic        dev_data_oe;
  logic        dev_rd_n_o;
  logic        dev_wr_n_o;
  logic        dev_memory_request_n_n_o;
  logic        dev_io_request_n_n_o;
  logic        dev_m1_n_o;
  logic        dev_strobe_oe;
  logic        dev_memory_request_n_oe;
  logic        dev_m1_oe;
  // far end drive
  logic [15:0] far_addr_o;
  logic        far_addr_oe;
  logic [7:0]  far_data_o;
  logic        far_data_oe;
  logic        far_rd_n_o;
  logic        far_wr_n_o;
  logic        far_io_request_n_n_o;
  logic        far_strobe_oe;
  // resolved levels, idle high
  logic [15:0] addr_lines;
  logic [7:0]  data_lines;
  logic        read_n;
  logic        write_n;
  logic        memory_request_n;
  logic        io_request_n;
  logic        opcode_fetch_n;

  assign addr_lines       = dev_addr_oe ? dev_addr_o : (far_addr_oe ? far_addr_o : 16'hffff);
  assign data_lines       = dev_data_oe ? dev_data_o : (far_data_oe ? far_data_o : 8'hff);
  assign read_n           = dev_strobe_oe ? dev_rd_n_o : (far_strobe_oe ? far_rd_n_o : 1'b1);
  assign write_n          = dev_strobe_oe ? dev_wr_n_o : (far_strobe_oe ? far_wr_n_o : 1'b1);
  assign io_request_n     = dev_strobe_oe ? dev_io_request_n_n_o : (far_strobe_oe ? far_io_request_n_n_o : 1'b1);
  assign memory_request_n = dev_memory_request_n_oe ? dev_memory_request_n_n_o : 1'b1;
  assign opcode_fetch_n   = dev_m1_oe ? dev_m1_n_o : 1'b1;

  modport device (
    output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe, dev_rd_n_o, dev_wr_n_o,
    output dev_memory_request_n_n_o, dev_io_request_n_n_o, dev_m1_n_o, dev_strobe_oe, dev_memory_request_n_oe, dev_m1_oe,
    input  addr_lines, data_lines, read_n, write_n, io_request_n
  );
  modport far (
    output far_addr_o, far_addr_oe, far_data_o, far_data_oe, far_rd_n_o, far_wr_n_o,
    output far_io_request_n_n_o, far_strobe_oe,
    input  addr_lines, data_lines, read_n, write_n, memory_request_n, io_request_n, opcode_fetch_n
  );
endinterface

/* File: verilog/ext_bus_device.sv */
// ext_bus_device: processor end of the external bus, cycle sequencer and
// peripheral slave port for an outside master
// assumes: far end drives pins only while ext_master is high
`timescale 1ns/1ps
module ext_bus_device (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // bus pins
  ext_bus_if.device                     bus,
  // mode pins
  input  wire logic                     evaluation_mode,
  input  wire logic                     ext_master,
  // internal cycle request
  input  wire logic                     req_valid,
  input  ext_bus_pkg::cyc_kind_t        req_kind,
  input  wire logic [15:0]              req_addr,
  input  wire logic [7:0]               req_wdata,
  input  wire logic                     req_internal,
  input  wire logic [7:0]               req_periph_rdata,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [7:0]                    rsp_rdata,
  // on-chip peripheral port for outside master
  input  wire logic [7:0]               periph_rdata [4],
  output logic                          periph_wr,
  output logic [1:0]                    periph_sel,
  output logic [7:0]                    periph_wdata
);
  // ==========================================================
  // helpers
  function automatic logic periph_hit(input logic [15:0] a);
    return (a[7:0] & ext_bus_pkg::PERIPH_MASK) == ext_bus_pkg::PERIPH_BASE;
  endfunction

  // kinds that take data in under the read strobe
  function automatic logic kind_reads(input ext_bus_pkg::cyc_kind_t k);
    return k == ext_bus_pkg::CYC_MEM_RD || k == ext_bus_pkg::CYC_IO_RD || k == ext_bus_pkg::CYC_FETCH;
  endfunction

  // kinds that put data out under the write strobe
  function automatic logic kind_writes(input ext_bus_pkg::cyc_kind_t k);
    return k == ext_bus_pkg::CYC_MEM_WR || k == ext_bus_pkg::CYC_IO_WR;
  endfunction

  // kinds with a valid memory address on the bus
  function automatic logic kind_memory(input ext_bus_pkg::cyc_kind_t k);
    return k == ext_bus_pkg::CYC_MEM_RD || k == ext_bus_pkg::CYC_MEM_WR
           || k == ext_bus_pkg::CYC_FETCH || k == ext_bus_pkg::CYC_REFRESH;
  endfunction

  // kinds that lower the io request strobe
  function automatic logic kind_io(input ext_bus_pkg::cyc_kind_t k);
    return k == ext_bus_pkg::CYC_IO_RD || k == ext_bus_pkg::CYC_IO_WR || k == ext_bus_pkg::CYC_INT_ACK;
  endfunction

  // kinds that lower the fetch strobe
  function automatic logic kind_fetch(input ext_bus_pkg::cyc_kind_t k);
    return k == ext_bus_pkg::CYC_FETCH || k == ext_bus_pkg::CYC_INT_ACK;
  endfunction

  // ==========================================================
  // internal cycle sequencer
  ext_bus_pkg::phase_t    phase, next_phase;
  ext_bus_pkg::cyc_kind_t kind, next_kind;
  logic [15:0] addr, next_addr;
  logic [7:0]  wdata, next_wdata;
  logic        internal, next_internal;
  logic        next_rsp_valid;
  logic [7:0]  next_rsp_rdata;

  always_comb begin
    next_phase     = phase;
    next_kind      = kind;
    next_addr      = addr;
    next_wdata     = wdata;
    next_internal  = internal;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    case (phase)
      ext_bus_pkg::PH_IDLE: begin
        if (req_valid && !ext_master) begin
          next_phase    = ext_bus_pkg::PH_ADDR;
          next_kind     = req_kind;
          next_addr     = req_addr;
          next_wdata    = req_wdata;
          next_internal = req_internal;
        end
      end
      ext_bus_pkg::PH_ADDR:   next_phase = ext_bus_pkg::PH_STROBE;
      ext_bus_pkg::PH_STROBE: begin
        next_phase = ext_bus_pkg::PH_END;
        if (internal)
          next_rsp_rdata = req_periph_rdata;
        else
          next_rsp_rdata = bus.data_lines;
      end
      ext_bus_pkg::PH_END: begin
        next_phase     = ext_bus_pkg::PH_IDLE;
        next_rsp_valid = 1'b1;
      end
      default: next_phase = ext_bus_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= ext_bus_pkg::PH_IDLE;
      kind      <= ext_bus_pkg::CYC_FETCH;
      addr      <= ext_bus_pkg::ADDR_RESET;
      wdata     <= ext_bus_pkg::DATA_RESET;
      internal  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= ext_bus_pkg::DATA_RESET;
    end else begin
      phase     <= next_phase;
      kind      <= next_kind;
      addr      <= next_addr;
      wdata     <= next_wdata;
      internal  <= next_internal;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  assign req_ready = (phase == ext_bus_pkg::PH_IDLE) && !ext_master;

  // ==========================================================
  // pin data register
  logic [7:0] drive_data, next_drive_data;
  always_comb begin
    if (ext_master)
      next_drive_data = periph_rdata[bus.addr_lines[ext_bus_pkg::PERIPH_SEL_W-1:0]];
    else if (next_internal && !kind_writes(next_kind))
      next_drive_data = req_periph_rdata;
    else
      next_drive_data = next_wdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      drive_data <= ext_bus_pkg::DATA_RESET;
    else
      drive_data <= next_drive_data;
  end

  // ==========================================================
  // pin drive
  logic active, strobe, is_rd, is_wr, is_mem, is_io;
  always_comb begin
    active = phase != ext_bus_pkg::PH_IDLE;
    strobe = phase == ext_bus_pkg::PH_STROBE;
    is_rd  = kind_reads(kind);
    is_wr  = kind_writes(kind);
    is_mem = kind_memory(kind);
    is_io  = kind_io(kind);
  end

  // each fetch cycle, incl. each byte of a two-byte opcode, gets its own strobe
  assign bus.dev_addr_o    = addr;
  assign bus.dev_addr_oe   = active && !ext_master;
  assign bus.dev_data_o    = drive_data;
  // data out on writes, on internal peripheral cycles, or outside-master peripheral reads
  assign bus.dev_data_oe   = ext_master ? (periph_hit(bus.addr_lines) && !bus.read_n && !bus.io_request_n)
                           : (active && (is_wr || internal) && kind != ext_bus_pkg::CYC_INT_ACK);
  assign bus.dev_rd_n_o    = !(strobe && is_rd);
  assign bus.dev_wr_n_o    = !(strobe && is_wr);
  assign bus.dev_memory_request_n_n_o  = !(strobe && is_mem);
  assign bus.dev_io_request_n_n_o  = !(strobe && is_io);
  assign bus.dev_m1_n_o    = !(strobe && kind_fetch(kind));
  assign bus.dev_strobe_oe = !ext_master;
  assign bus.dev_memory_request_n_oe   = !ext_master;
  assign bus.dev_m1_oe     = !evaluation_mode;

  // ==========================================================
  // outside master peripheral port
  logic       next_periph_wr;
  logic [1:0] next_periph_sel;
  logic [7:0] next_periph_wdata;
  logic       wr_seen, next_wr_seen;
  always_comb begin
    next_periph_sel   = bus.addr_lines[ext_bus_pkg::PERIPH_SEL_W-1:0];
    next_periph_wdata = periph_wdata;
    next_periph_wr    = 1'b0;
    next_wr_seen      = 1'b0;
    if (ext_master && periph_hit(bus.addr_lines) && !bus.io_request_n && !bus.write_n) begin
      next_wr_seen      = 1'b1;
      next_periph_wdata = bus.data_lines;
      next_periph_wr    = !wr_seen;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_wr    <= 1'b0;
      periph_sel   <= '0;
      periph_wdata <= ext_bus_pkg::DATA_RESET;
      wr_seen      <= 1'b0;
    end else begin
      periph_wr    <= next_periph_wr;
      periph_sel   <= next_periph_sel;
      periph_wdata <= next_periph_wdata;
      wr_seen      <= next_wr_seen;
    end
  end
endmodule

/* File: verilog/ext_bus_far.sv */
// ext_bus_far: outside master end, drives peripheral cycles into the device
// assumes: ext_master to the device is high for as long as own_bus is high
`timescale 1ns/1ps
module ext_bus_far (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus pins
  ext_bus_if.far           bus,
  // user request
  input  wire logic        own_bus,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_ready,
  output logic             done,
  output logic [7:0]       rdata
);
  // ==========================================================
  // cycle sequencer
  ext_bus_pkg::phase_t phase, next_phase;
  logic       wr, next_wr;
  logic [7:0] addr, next_addr;
  logic [7:0] wdata, next_wdata;
  logic       next_done;
  logic [7:0] next_rdata;

  always_comb begin
    next_phase = phase;
    next_wr    = wr;
    next_addr  = addr;
    next_wdata = wdata;
    next_done  = 1'b0;
    next_rdata = rdata;
    case (phase)
      ext_bus_pkg::PH_IDLE: begin
        if (cmd_valid && own_bus) begin
          next_phase = ext_bus_pkg::PH_ADDR;
          next_wr    = cmd_write;
          next_addr  = cmd_addr;
          next_wdata = cmd_wdata;
        end
      end
      ext_bus_pkg::PH_ADDR:   next_phase = ext_bus_pkg::PH_STROBE;
      ext_bus_pkg::PH_STROBE: begin
        next_phase = ext_bus_pkg::PH_END;
        if (!wr)
          next_rdata = bus.data_lines;
      end
      ext_bus_pkg::PH_END: begin
        next_phase = ext_bus_pkg::PH_IDLE;
        next_done  = 1'b1;
      end
      default: next_phase = ext_bus_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ext_bus_pkg::PH_IDLE;
      wr    <= 1'b0;
      addr  <= ext_bus_pkg::DATA_RESET;
      wdata <= ext_bus_pkg::DATA_RESET;
      done  <= 1'b0;
      rdata <= ext_bus_pkg::DATA_RESET;
    end else begin
      phase <= next_phase;
      wr    <= next_wr;
      addr  <= next_addr;
      wdata <= next_wdata;
      done  <= next_done;
      rdata <= next_rdata;
    end
  end

  assign cmd_ready = (phase == ext_bus_pkg::PH_IDLE) && own_bus;

  // ==========================================================
  // pin drive
  logic strobe;
  assign strobe            = phase == ext_bus_pkg::PH_STROBE;
  assign bus.far_addr_o    = {8'h00, addr};
  assign bus.far_addr_oe   = own_bus;
  assign bus.far_data_o    = wdata;
  assign bus.far_data_oe   = own_bus && wr && phase != ext_bus_pkg::PH_IDLE;
  assign bus.far_rd_n_o    = !(strobe && !wr);
  assign bus.far_wr_n_o    = !(strobe && wr);
  assign bus.far_io_request_n_n_o  = !strobe;
  assign bus.far_strobe_oe = own_bus;
endmodule

/* File: test/ext_bus_checker.sv */
// ext_bus_checker: assertions on the external bus lines and drive enables
// assumes: instantiated beside the interface, one clock domain
`timescale 1ns/1ps
module ext_bus_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // mode and bus lines
  input wire logic        evaluation_mode,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        opcode_fetch_n,
  // drive enables
  input wire logic        dev_addr_oe,
  input wire logic        dev_data_oe,
  input wire logic        dev_strobe_oe,
  input wire logic        dev_memory_request_n_oe,
  input wire logic        dev_m1_oe,
  input wire logic        far_addr_oe,
  input wire logic        far_strobe_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // strobe sequences
  sequence fetch_low; $fell(opcode_fetch_n); endsequence
  sequence fetch_ends; ##1 opcode_fetch_n; endsequence
  a_fetch_memory_request_n: assert property (!opcode_fetch_n && io_request_n |-> !memory_request_n)
    else $error("fetch strobe without memory request");
  a_fetch_byte: assert property (fetch_low |-> fetch_ends)
    else $error("fetch strobe not one per byte");
  a_intack_pair: assert property (!opcode_fetch_n && !io_request_n |-> memory_request_n && !dev_data_oe)
    else $error("bad interrupt acknowledge strobes");
  a_memory_request_n_addr: assert property ($fell(memory_request_n) |-> dev_addr_oe && $past(dev_addr_oe))
    else $error("memory request without address");
  a_io_addr: assert property (!io_request_n && dev_strobe_oe |-> dev_addr_oe)
    else $error("io request without address");
  a_write_data: assert property (!write_n && dev_strobe_oe |-> dev_data_oe)
    else $error("write strobe without data");
  a_read_pulse: assert property ($fell(read_n) && dev_strobe_oe |-> ##1 read_n)
    else $error("read strobe too long");
  a_addr_input: assert property (far_addr_oe |-> !dev_addr_oe && !dev_strobe_oe)
    else $error("device drives during outside master");
  a_memory_request_n_float: assert property (far_strobe_oe |-> !dev_memory_request_n_oe && memory_request_n)
    else $error("memory request driven during outside master");
  a_m1_float: assert property (evaluation_mode |-> !dev_m1_oe && opcode_fetch_n)
    else $error("fetch strobe driven in evaluation mode");
  a_read_drive: assert property (dev_data_oe && far_strobe_oe |-> !read_n && !io_request_n)
    else $error("peripheral data driven outside read");
endmodule

/* File: test/cpu_external_bus_interface_test.sv */
// cpu_external_bus_interface_test: both bus ends joined, driven from user sides
// assumes: 25 MHz clock, far end owns the bus only while own_bus is high
`timescale 1ns/1ps
module cpu_external_bus_interface_test;
  logic clk, rst_n, evaluation_mode, own_bus, req_valid, req_internal, req_ready, rsp_valid;
  ext_bus_pkg::cyc_kind_t req_kind;
  logic [15:0] req_addr;
  logic [7:0] req_wdata, req_periph_rdata, rsp_rdata, periph_wdata, cmd_addr, cmd_wdata, rdata;
  logic [7:0] periph_rdata [4];
  logic periph_wr, cmd_valid, cmd_write, cmd_ready, done;
  logic [1:0] periph_sel;
  int num_errors = 0;
  int n_tests = 0;
  ext_bus_if ext_bus_if_i ();
  ext_bus_device ext_bus_device_i (.clk(clk), .rst_n(rst_n), .bus(ext_bus_if_i), .evaluation_mode(evaluation_mode),
    .ext_master(own_bus), .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_internal(req_internal), .req_periph_rdata(req_periph_rdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .periph_rdata(periph_rdata), .periph_wr(periph_wr),
    .periph_sel(periph_sel), .periph_wdata(periph_wdata));
  ext_bus_far ext_bus_far_i (.clk(clk), .rst_n(rst_n), .bus(ext_bus_if_i), .own_bus(own_bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
    .rdata(rdata));
  ext_bus_checker ext_bus_checker_i (.clk(clk), .rst_n(rst_n), .evaluation_mode(evaluation_mode),
    .read_n(ext_bus_if_i.read_n), .write_n(ext_bus_if_i.write_n), .memory_request_n(ext_bus_if_i.memory_request_n),
    .io_request_n(ext_bus_if_i.io_request_n), .opcode_fetch_n(ext_bus_if_i.opcode_fetch_n),
    .dev_addr_oe(ext_bus_if_i.dev_addr_oe), .dev_data_oe(ext_bus_if_i.dev_data_oe),
    .dev_strobe_oe(ext_bus_if_i.dev_strobe_oe), .dev_memory_request_n_oe(ext_bus_if_i.dev_memory_request_n_oe),
    .dev_m1_oe(ext_bus_if_i.dev_m1_oe), .far_addr_oe(ext_bus_if_i.far_addr_oe),
    .far_strobe_oe(ext_bus_if_i.far_strobe_oe));
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // s bits: memory request, io request, fetch, read, write (1 = low on wire)
  task automatic dev_cyc(input ext_bus_pkg::cyc_kind_t k, input logic [15:0] a, input logic [7:0] d,
    input logic in, input logic [4:0] es, input logic [7:0] er);
    logic [4:0] s;
    logic [15:0] sa;
    logic [7:0] sd;
    int i;
    s = '0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    req_periph_rdata <= d;
    req_internal <= in;
    i = 0;
    @(posedge clk);
    while (!req_ready && i < 20) begin
      i++;
      @(posedge clk);
    end
    req_valid <= 1'b0;
    for (i = 0; i < 8 && !rsp_valid; i++) begin
      @(posedge clk);
      #1;
      if (!(ext_bus_if_i.memory_request_n & ext_bus_if_i.io_request_n & ext_bus_if_i.opcode_fetch_n
            & ext_bus_if_i.read_n & ext_bus_if_i.write_n)) begin
        s = ~{ext_bus_if_i.memory_request_n, ext_bus_if_i.io_request_n, ext_bus_if_i.opcode_fetch_n,
              ext_bus_if_i.read_n, ext_bus_if_i.write_n};
        sa = ext_bus_if_i.addr_lines;
        sd = ext_bus_if_i.data_lines;
      end
    end
    chk("rsp_valid", 16'h0001, rsp_valid);
    chk("strobes", es, s);
    if (es[4] || (es[3] && !es[2])) chk("addr_lines", a, sa);
    if (es[0] || in) chk("data_lines", d, sd);
    if (es[1]) chk("rsp_rdata", er, rsp_rdata);
  endtask
  task automatic far_cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [8:0] pw;
    logic [7:0] sd;
    logic inw;
    int i;
    pw = '0;
    sd = '0;
    inw = (a & ext_bus_pkg::PERIPH_MASK) == ext_bus_pkg::PERIPH_BASE;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    i = 0;
    @(posedge clk);
    while (!cmd_ready && i < 20) begin
      i++;
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    for (i = 0; i < 8 && !done; i++) begin
      @(posedge clk);
      #1;
      if (!ext_bus_if_i.io_request_n) chk("far addr_lines", {8'h00, a}, ext_bus_if_i.addr_lines);
      if (!ext_bus_if_i.io_request_n) sd = ext_bus_if_i.data_lines;
      if (periph_wr) pw = {1'b1, periph_wdata};
      if (periph_wr) chk("periph_sel", a[1:0], periph_sel);
    end
    chk("req_ready", 16'h0000, req_ready);
    chk("done", 16'h0001, done);
    chk("cmd_ready", 16'h0001, cmd_ready);
    if (w) chk("periph_wr", inw ? {1'b1, d} : 9'h000, pw);
    else chk("rdata", inw ? periph_rdata[a[1:0]] : 8'hff, rdata);
    if (!w) chk("far data_lines", inw ? periph_rdata[a[1:0]] : 8'hff, sd);
  endtask
  // ==========================================
  // clock, reset and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    {rst_n, evaluation_mode, own_bus, req_valid, req_internal, cmd_valid, cmd_write} = '0;
    {req_addr, req_wdata, req_periph_rdata, cmd_addr, cmd_wdata} = '0;
    req_kind = ext_bus_pkg::CYC_FETCH;
    periph_rdata = '{8'h11, 8'h22, 8'h33, 8'h44};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    dev_cyc(ext_bus_pkg::CYC_FETCH, 16'h0100, 8'h00, 0, 5'b10110, 8'hff);
    dev_cyc(ext_bus_pkg::CYC_FETCH, 16'h0101, 8'h00, 0, 5'b10110, 8'hff);
    dev_cyc(ext_bus_pkg::CYC_MEM_RD, 16'hfffe, 8'h00, 0, 5'b10010, 8'hff);
    dev_cyc(ext_bus_pkg::CYC_MEM_WR, 16'h8001, 8'ha5, 0, 5'b10001, 8'h00);
    dev_cyc(ext_bus_pkg::CYC_IO_RD, 16'h0040, 8'h00, 0, 5'b01010, 8'hff);
    dev_cyc(ext_bus_pkg::CYC_IO_WR, 16'h00ff, 8'h3c, 0, 5'b01001, 8'h00);
    dev_cyc(ext_bus_pkg::CYC_INT_ACK, 16'h0000, 8'h00, 0, 5'b01100, 8'h00);
    dev_cyc(ext_bus_pkg::CYC_REFRESH, 16'h007f, 8'h00, 0, 5'b10000, 8'h00);
    dev_cyc(ext_bus_pkg::CYC_IO_WR, 16'h0012, 8'h5a, 1, 5'b01001, 8'h00);
    dev_cyc(ext_bus_pkg::CYC_IO_RD, 16'h0011, 8'hc3, 1, 5'b01010, 8'hc3);
    evaluation_mode <= 1'b1;
    dev_cyc(ext_bus_pkg::CYC_FETCH, 16'h0200, 8'h00, 0, 5'b10010, 8'hff);
    evaluation_mode <= 1'b0;
    own_bus <= 1'b1;
    far_cyc(1, 8'h12, 8'ha5);
    far_cyc(0, 8'h11, 8'h00);
    far_cyc(0, 8'h13, 8'h00);
    far_cyc(1, 8'h20, 8'h77);
    far_cyc(0, 8'h20, 8'h00);
    own_bus <= 1'b0;
    dev_cyc(ext_bus_pkg::CYC_MEM_WR, 16'h1234, 8'h81, 0, 5'b10001, 8'h00);
    report_and_stop();
  end
endmodule
